// ### hw/tsc_pkg.sv
/*
  Shared constants for the touch converter serial link: control byte
  fields, power-down codes, channel codes and frame timing.
  Assumes both ends and the bench import it.
*/
package tsc_pkg;
  localparam int CMD_BITS      = 8;
  localparam int START_POS     = 7;
  localparam int CHAN_HI       = 6;
  localparam int CHAN_LO       = 4;
  localparam int RES_POS       = 3;
  localparam int REF_POS       = 2;
  localparam int PD_HI         = 1;
  localparam int PD_LO         = 0;
  localparam int RESULT_BITS   = 12;
  localparam int SHORT_BITS    = 8;
  localparam int ACQ_CLOCKS    = 3;
  localparam int FRAME_12      = 15;
  localparam int FRAME_8       = 11;
  localparam int FRAME_16      = 16;
  localparam logic [4:0] CNT_W0 = 5'h00;
  localparam logic [2:0] CHAN_Y    = 3'h1;
  localparam logic [2:0] CHAN_X    = 3'h5;
  localparam logic [2:0] CHAN_AUX  = 3'h2;
  localparam logic [2:0] CHAN_TOUCH = 3'h6;
  localparam logic [1:0] PD_AUTO_PEN = 2'h0;
  localparam logic [1:0] PD_AUTO     = 2'h1;
  localparam logic [1:0] PD_RESERVED = 2'h2;
  localparam logic [1:0] PD_ON       = 2'h3;
  localparam logic [7:0] CMD_RESET  = 8'h00;
  localparam logic [11:0] RESULT_RESET = 12'h000;
  localparam real LINK_PERIOD_NS = 160.0;
  localparam real MCLK_PERIOD_NS = 10.0;
  localparam int  HALF_DIV = int'(LINK_PERIOD_NS / MCLK_PERIOD_NS) / 2;
  localparam real HOLD_MAX_US = 1600.0;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CMD  = 2'b01,
    ST_ACQ  = 2'b10,
    ST_CONV = 2'b11
  } tsc_state_e;
endpackage

// ### hw/tsc_link_if.sv
/*
  Serial link between host and converter: chip select, serial clock,
  command input and tri-state result output.
  Assumes the bench resolves the data output wire from its enable.
*/
`timescale 1ns/1ps
`default_nettype none
interface tsc_link_if;
  logic csN;
  logic serialClock;
  logic cmdData;
  logic resultData;
  logic resultOeN;
  modport device (input csN, input serialClock, input cmdData,
                  output resultData, output resultOeN);
  modport host (output csN, output serialClock, output cmdData,
                input resultData, input resultOeN);
endinterface
`default_nettype wire

// ### hw/tsc_sync2.sv
/*
  Two-stage synchroniser for a level from another domain.
  Assumes din is asynchronous to mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module tsc_sync2 (
  // clock and reset
  input  wire logic mclk,
  input  wire logic nrst,
  // level
  input  wire logic din,
  output logic      dout
);
  logic stage1_reg;
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      stage1_reg <= 1'b0;
      dout       <= 1'b0;
    end
    else
    begin
      stage1_reg <= din;
      dout       <= stage1_reg;
    end
  end
endmodule
`default_nettype wire

// ### hw/tsc_device.sv
/*
  Converter end of the serial link: command parsing, acquisition and
  conversion sequencing, result shifting, power-down and switch control.
  Assumes the analog value arrives as a parallel sample and the touch
  sense as a level; link pins are sampled on mclk.
*/
// Contract
// RL1 - command starts with high marker bit seven
// RL2 - ignore input bits until marker seen
// RL3 - bits six to four select channel
// RL4 - bit three low twelve, high eight bits
// RL5 - bit two high single ended reference
// RL6 - new command every 15th or 11th clock
// RL7 - code 11 keeps device fully powered
// RL8 - code 00 powers down, lower right on, pen
// RL9 - code 01 powers down, no pen, switch off
// RL10 - host never issues reserved code 10
// RL11 - next command overlaps result, sixteen clocks
// RL12 - host completes conversion within 1.6 ms
// RL13 - fifteen clock back to back framing sustained
// RL14 - results are unsigned straight binary
// RL15 - eight bit conversion ends four clocks earlier
// RL16 - switches on acquisition, differential also conversion
// RL17 - three acquisition clocks then result bits
// RL18 - touch channel powerdown reports all touch bits
// RL19 - output high impedance while select high
// RL20 - sample rising edges, shift falling, msb first
`timescale 1ns/1ps
`default_nettype none
module tsc_device
  import tsc_pkg::*;
(
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       nrst,
  // link
  tsc_link_if.device      link,
  // analog side
  input  wire logic [11:0] sampleValue,
  input  wire logic        panelTouched,
  // status towards the analog side
  output logic [2:0]       channelSelect,
  output logic             referenceModeSelect,
  output logic [1:0]       powerdownSelect,
  output logic             switchesOn,
  output logic             lowerRightSwitch,
  output logic             penDetectEnable,
  output logic             powerDown,
  output logic             sampleHold,
  output logic             penTouchIrq
);
  logic       csN;
  logic       sclk;
  logic       din;
  logic       sclkPrev_reg;
  logic       rise;
  logic       fall;
  tsc_state_e state_reg;
  logic [2:0] bitCnt_reg;
  logic [5:0] cmd_reg;
  logic [7:0] fullCmd;
  logic       cmdDone;
  logic [3:0] outCnt_reg;
  logic [12:0] shift_reg;
  logic       converting;
  logic       touchPoll;

  tsc_sync2 uCs (.mclk(mclk), .nrst(nrst), .din(link.csN), .dout(csN));
  tsc_sync2 uClk (.mclk(mclk), .nrst(nrst), .din(link.serialClock), .dout(sclk));
  tsc_sync2 uDin (.mclk(mclk), .nrst(nrst), .din(link.cmdData), .dout(din));

  always_ff @(posedge mclk)
  begin
    if (!nrst)
      sclkPrev_reg <= 1'b0;
    else
      sclkPrev_reg <= sclk;
  end

  assign rise = sclk & ~sclkPrev_reg & ~csN; // [RL20]
  // falls stay live at deselect so a cut frame still drains its bit
  assign fall = ~sclk & sclkPrev_reg;
  assign converting = (state_reg == ST_CONV);
  // touch sense replaces the whole result word
  assign touchPoll = (channelSelect == CHAN_TOUCH)
                     && (powerdownSelect == PD_AUTO_PEN); // [RL18]
  // whole byte known at the rise carrying its last bit
  assign fullCmd = {1'b1, cmd_reg, din};
  assign cmdDone = rise && (state_reg == ST_ACQ)
                   && (bitCnt_reg == 3'(CMD_BITS - 1)); // [RL17]

  // command parse and sequencing on rising serial clock edges
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      state_reg  <= ST_IDLE;
      bitCnt_reg <= 3'h0;
      cmd_reg    <= 6'h00;
    end
    else if (rise)
    begin
      // a new start bit may arrive during conversion: overlapped framing
      if (din && state_reg != ST_CMD && state_reg != ST_ACQ) // [RL1] [RL2] [RL6] [RL11] [RL13]
      begin
        state_reg  <= ST_CMD;
        bitCnt_reg <= 3'h1;
      end
      else
      begin
        case (state_reg)
          ST_IDLE:
            state_reg <= ST_IDLE; // [RL2]
          ST_CMD:
          begin
            cmd_reg    <= {cmd_reg[4:0], din};
            bitCnt_reg <= bitCnt_reg + 3'h1;
            if (bitCnt_reg == 3'(CMD_BITS - ACQ_CLOCKS - 1))
              state_reg <= ST_ACQ; // [RL17]
          end
          ST_ACQ:
          begin
            cmd_reg    <= {cmd_reg[4:0], din};
            bitCnt_reg <= bitCnt_reg + 3'h1;
            if (cmdDone)
              state_reg <= ST_CONV; // [RL16] [RL17]
          end
          ST_CONV:
          begin
            // result drained: rest until the next start bit
            if (outCnt_reg == 4'h0)
              state_reg <= ST_IDLE;
          end
          default:
            state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  // configuration fields once the byte is known
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      channelSelect       <= 3'h0;
      referenceModeSelect <= 1'b1;
      powerdownSelect     <= PD_AUTO_PEN;
    end
    else if (cmdDone)
    begin
      channelSelect       <= fullCmd[CHAN_HI:CHAN_LO]; // [RL3]
      referenceModeSelect <= fullCmd[REF_POS]; // [RL5]
      powerdownSelect     <= fullCmd[PD_HI:PD_LO]; // [RL7] [RL8] [RL9]
    end
  end

  // result shifter: sample loaded at hold, msb out on falling edges
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      shift_reg  <= 13'h0000;
      outCnt_reg <= 4'h0;
    end
    else if (cmdDone)
    begin
      // one idle bit ahead of the msb, then the word
      shift_reg  <= {1'b0, sampleValue}; // [RL14]
      outCnt_reg <= fullCmd[RES_POS] ? 4'(SHORT_BITS + 1) : 4'(RESULT_BITS + 1); // [RL4] [RL15]
    end
    else if (fall && outCnt_reg != 4'h0)
    begin
      // keeps draining after a new start bit: overlapped framing
      shift_reg  <= {shift_reg[11:0], 1'b0}; // [RL11] [RL20]
      outCnt_reg <= outCnt_reg - 4'h1;
    end
  end

  // analog side controls
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      switchesOn       <= 1'b0;
      sampleHold       <= 1'b0;
      powerDown        <= 1'b1;
      lowerRightSwitch <= 1'b0;
      penDetectEnable  <= 1'b0;
    end
    else
    begin
      switchesOn <= (state_reg == ST_ACQ)
                    || (converting && !referenceModeSelect); // [RL16]
      sampleHold <= converting;
      powerDown  <= (state_reg == ST_IDLE) && (powerdownSelect != PD_ON); // [RL7] [RL8] [RL9]
      lowerRightSwitch <= (state_reg == ST_IDLE) && (powerdownSelect == PD_AUTO_PEN); // [RL8]
      penDetectEnable  <= (powerdownSelect == PD_AUTO_PEN); // [RL8] [RL9] [RL10]
    end
  end

  // pen level and data pin
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      penTouchIrq     <= 1'b0;
      link.resultData <= 1'b0;
      link.resultOeN  <= 1'b1;
    end
    else
    begin
      penTouchIrq    <= penDetectEnable && powerDown && panelTouched;
      link.resultOeN <= csN; // [RL19]
      // pin moves only after a link clock fall
      if (fall)
      begin
        if (touchPoll)
          link.resultData <= panelTouched; // [RL18]
        else if (outCnt_reg != 4'h0)
          link.resultData <= shift_reg[12]; // [RL20]
        else
          link.resultData <= 1'b0; // [RL17]
      end
    end
  end
endmodule
`default_nettype wire

// ### hw/tsc_host.sv
/*
  Host end: drives select, divided serial clock and command bits,
  collects result bits. One transfer of frameLen clocks per request.
  Assumes the user keeps the command stable while busy is high.
*/
`timescale 1ns/1ps
`default_nettype none
module tsc_host
  import tsc_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        nrst,
  // link
  tsc_link_if.host         link,
  // user request
  input  wire logic        start,
  input  wire logic [7:0]  command,
  input  wire logic [4:0]  frameLen,
  // user answer
  output logic             busy,
  output logic             done,
  output logic [11:0]      result
);
  logic [7:0]  div_reg;
  logic [4:0]  clkCnt_reg;
  logic [7:0]  cmd_reg;
  logic [15:0] rx_reg;
  logic        dataIn;

  tsc_sync2 uDat (.mclk(mclk), .nrst(nrst), .din(link.resultData), .dout(dataIn));

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      busy             <= 1'b0;
      done             <= 1'b0;
      result           <= RESULT_RESET;
      div_reg          <= 8'h00;
      clkCnt_reg       <= CNT_W0;
      cmd_reg          <= CMD_RESET;
      rx_reg           <= 16'h0000;
      link.csN         <= 1'b1;
      link.serialClock <= 1'b0;
      link.cmdData     <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (!busy)
      begin
        if (start)
        begin
          busy         <= 1'b1;
          link.csN     <= 1'b0;
          cmd_reg      <= {command[6:0], 1'b0};
          link.cmdData <= command[START_POS]; // [RL1] [RL20]
          clkCnt_reg   <= CNT_W0;
          div_reg      <= 8'h00;
        end
      end
      else if (div_reg == 8'(HALF_DIV - 1))
      begin
        div_reg          <= 8'h00;
        link.serialClock <= ~link.serialClock;
        if (link.serialClock)
        begin
          // falling edge: next command bit, count the clock
          link.cmdData <= cmd_reg[7];
          cmd_reg      <= {cmd_reg[6:0], 1'b0};
          clkCnt_reg   <= clkCnt_reg + 5'h01;
          if (clkCnt_reg == frameLen - 5'h01) // [RL10] [RL12]
          begin
            busy     <= 1'b0;
            done     <= 1'b1;
            link.csN <= 1'b1;
            result   <= rx_reg[11:0];
          end
        end
        else
          rx_reg <= {rx_reg[14:0], dataIn};
      end
      else
        div_reg <= div_reg + 8'h01;
    end
  end
endmodule
`default_nettype wire

// ### verification/tsc_link_monitor.sv
/*
  Checker on the serial link between host and converter ends.
  Assumes it sits beside the link interface, fed from its signals.
*/
`timescale 1ns/1ps
`default_nettype none
module tsc_link_monitor (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // link
  input wire logic csN,
  input wire logic serialClock,
  input wire logic cmdData,
  input wire logic resultData,
  input wire logic resultOeN
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  idle_pin_float_a: assert property (csN [*4] |-> resultOeN)
    else $error("data pin driven while deselected");
  release_time_a: assert property ($rose(csN) |-> ##[1:4] resultOeN)
    else $error("data pin not released after deselect");
  dout_on_fall_a: assert property (!resultOeN && $changed(resultData) |-> !serialClock)
    else $error("result bit moved while link clock high");
  din_on_low_a: assert property (!csN && $changed(cmdData) |-> !serialClock)
    else $error("command bit moved while link clock high");
  start_marker_a: assert property ($fell(csN) |-> cmdData)
    else $error("frame opened without high marker bit");
  select_clk_low_a: assert property ($fell(csN) |-> !serialClock)
    else $error("frame opened with link clock high");
  clk_high_len_a: assert property ($rose(serialClock) |-> serialClock [*8] ##1 !serialClock)
    else $error("link clock high phase not eight cycles");
  clk_low_len_a: assert property ($fell(serialClock) |-> !serialClock [*8])
    else $error("link clock low phase too short");
  idle_clk_low_a: assert property (csN && $past(csN) |-> !serialClock)
    else $error("link clock running outside a frame");
endmodule
`default_nettype wire

// ### verification/tb.sv
/*
  Self-checking bench: host and converter ends joined by the link.
  Assumes the host frames each request and the converter pin is judged.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tsc_pkg::*;
  logic        mclk;
  logic        nrst;
  logic        start;
  logic [7:0]  command;
  logic [4:0]  frameLen;
  logic [11:0] sampleValue;
  logic        panelTouched;
  logic        done;
  logic [11:0] hostResult;
  logic [2:0]  channelSelect;
  logic        referenceModeSelect;
  logic [1:0]  powerdownSelect;
  logic        switchesOn;
  logic        lowerRightSwitch;
  logic        penDetectEnable;
  logic        powerDown;
  logic        penTouchIrq;
  logic [23:0] frameBits;
  logic        swAcq;
  logic        swConv;
  int          rises;
  int          num_errors;
  int          check_count;

  tsc_link_if link ();
  tsc_host i_tsc_host (.mclk(mclk), .nrst(nrst), .link(link), .start(start),
    .command(command), .frameLen(frameLen), .busy(), .done(done), .result(hostResult));
  tsc_device i_tsc_device (.mclk(mclk), .nrst(nrst), .link(link),
    .sampleValue(sampleValue), .panelTouched(panelTouched),
    .channelSelect(channelSelect), .referenceModeSelect(referenceModeSelect),
    .powerdownSelect(powerdownSelect), .switchesOn(switchesOn),
    .lowerRightSwitch(lowerRightSwitch), .penDetectEnable(penDetectEnable),
    .powerDown(powerDown), .sampleHold(), .penTouchIrq(penTouchIrq));
  tsc_link_monitor i_tsc_link_monitor (.mclk(mclk), .nrst(nrst), .csN(link.csN),
    .serialClock(link.serialClock), .cmdData(link.cmdData),
    .resultData(link.resultData), .resultOeN(link.resultOeN));

  initial
  begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end

  // pin bits as seen on each rising link clock of a frame
  always @(posedge link.serialClock)
    if (!link.csN)
    begin
      frameBits <= {frameBits[22:0], link.resultData};
      rises = rises + 1;
      if (rises == 7) swAcq <= switchesOn;
      if (rises == 14) swConv <= switchesOn;
    end

  task automatic close_out();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic xfer(input logic [7:0] cmd, input logic [4:0] len,
                      input logic [11:0] samp, input logic touch);
    int n;
    @(posedge mclk);
    command      <= cmd;
    frameLen     <= len;
    sampleValue  <= samp;
    panelTouched <= touch;
    start        <= 1'h1;
    rises = 0;
    @(posedge mclk);
    start <= 1'h0;
    n = 0;
    while (done !== 1'h1 && n < 3000)
    begin
      @(negedge mclk);
      n++;
    end
    if (n >= 3000)
    begin
      num_errors++;
      close_out();
    end
    repeat (4) @(negedge mclk);
    chk("frame clocks", 24'(len), 24'(rises));
  endtask

  task automatic t_result();
    logic [11:0] s [3] = '{12'hA5C, 12'h000, 12'hFFF};
    foreach (s[i])
    begin
      xfer({1'h1, CHAN_Y, 1'h0, 1'h1, PD_ON}, 5'h18, s[i], 1'h0);
      chk("result", 24'(s[i]), 24'(frameBits[14:3]));
      chk("tail", 24'h0, 24'(frameBits[2:0]));
      chk("host word", 24'({s[i][8:0], 3'h0}), 24'(hostResult));
      chk("channel", 24'(CHAN_Y), 24'(channelSelect));
      chk("ref mode", 24'h1, 24'(referenceModeSelect));
      chk("sw acq", 24'h1, 24'(swAcq));
      chk("sw conv", 24'h0, 24'(swConv));
    end
  endtask

  task automatic t_short();
    xfer({1'h1, CHAN_X, 1'h1, 1'h0, PD_ON}, 5'h18, 12'h9B7, 1'h0);
    chk("short result", 24'h9B, 24'(frameBits[14:7]));
    chk("short tail", 24'h0, 24'(frameBits[6:0]));
    chk("channel", 24'(CHAN_X), 24'(channelSelect));
    chk("ref mode", 24'h0, 24'(referenceModeSelect));
    chk("sw conv", 24'h1, 24'(swConv));
  endtask

  // reserved power-down code is never sent
  task automatic t_power();
    logic [1:0] pd [3] = '{PD_AUTO_PEN, PD_AUTO, PD_ON};
    foreach (pd[i])
    begin
      xfer({1'h1, CHAN_Y, 1'h0, 1'h1, pd[i]}, 5'h18, 12'h123, 1'h0);
      chk("pd select", 24'(pd[i]), 24'(powerdownSelect));
      chk("power down", 24'(pd[i] != PD_ON), 24'(powerDown));
      chk("lower right", 24'(pd[i] == PD_AUTO_PEN), 24'(lowerRightSwitch));
      chk("pen detect", 24'(pd[i] == PD_AUTO_PEN), 24'(penDetectEnable));
    end
  endtask

  task automatic t_touch();
    for (int t = 0; t < 2; t++)
    begin
      xfer({1'h1, CHAN_TOUCH, 1'h0, 1'h1, PD_AUTO_PEN}, 5'h18, 12'h456, 1'(t));
      xfer({1'h1, CHAN_TOUCH, 1'h0, 1'h1, PD_AUTO_PEN}, 5'h18, 12'h456, 1'(t));
      chk("touch poll", {24{1'(t)}}, frameBits);
      chk("pen irq", 24'(t), 24'(penTouchIrq));
    end
  endtask

  task automatic t_fast();
    xfer({1'h1, CHAN_Y, 1'h0, 1'h1, PD_ON}, 5'h0F, 12'h321, 1'h0);
    xfer({1'h1, CHAN_X, 1'h0, 1'h1, PD_ON}, 5'h0F, 12'h321, 1'h0);
    chk("fast channel", 24'(CHAN_X), 24'(channelSelect));
    xfer({1'h1, CHAN_Y, 1'h1, 1'h1, PD_ON}, 5'h0B, 12'h321, 1'h0);
    chk("short frame channel", 24'(CHAN_Y), 24'(channelSelect));
    xfer({1'h1, CHAN_AUX, 1'h0, 1'h1, PD_ON}, 5'h10, 12'h321, 1'h0);
    chk("overlap channel", 24'(CHAN_AUX), 24'(channelSelect));
  endtask

  initial
  begin
    nrst         = 1'h0;
    start        = 1'h0;
    command      = CMD_RESET;
    frameLen     = 5'h18;
    sampleValue  = 12'h000;
    panelTouched = 1'h0;
    num_errors   = 0;
    check_count  = 0;
    rises        = 0;
    repeat (10) @(posedge mclk);
    nrst <= 1'h1;
    t_result();
    t_short();
    t_power();
    t_touch();
    t_fast();
    close_out();
  end
endmodule
`default_nettype wire
